// >>> common/angle_lin_pkg.sv
// Constants shared by the angle linearization unit and its sine helper.
// Assumes angles are unsigned 16-bit fractions of one full rotation.
package angle_lin_pkg;
  localparam int ANGLE_W = 16;
  localparam int OUT_W = 12;
  localparam int SEG_COUNT = 16;
  localparam int SEG_BITS = 4;
  localparam int FRAC_W = ANGLE_W - SEG_BITS;
  localparam int HARM_COUNT = 15;
  // Coefficient store layout, one 16-bit word per location
  localparam logic [5:0] SEG_BASE = 6'h00;
  localparam logic [5:0] AMP_BASE = 6'h10;
  localparam logic [5:0] PHASE_BASE = 6'h1F;
  localparam logic [5:0] OPTION_ADDR = 6'h2E;
  localparam int COEF_WORDS = 47;
  localparam logic [5:0] LAST_ADDR = 6'h2E;
  // Option word fields
  localparam int OPT_HARM_BIT = 0;
  localparam int OPT_SEG_BIT = 1;
  localparam int OPT_SEL_LSB = 2;
  localparam logic [15:0] OPTION_RESET = 16'h0000;
  localparam logic [15:0] COEF_RESET = 16'h0000;
  // Segmented variants
  localparam logic [1:0] SEL_ABSOLUTE = 2'h0;
  localparam logic [1:0] SEL_OFFSET = 2'h1;
  // Mode shown on the status output
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_HARM = 2'h1;
  localparam logic [1:0] MODE_SEG = 2'h2;
  // Q1.15 sine scaling
  localparam int SINE_FRAC = 15;
  localparam logic signed [15:0] SINE_MAX = 16'sh7FFF;
endpackage : angle_lin_pkg

// >>> rtl/sine_approx.sv
// Registered sine approximation for a 16-bit rotation phase, Q1.15 result.
// Assumes one new phase per clock; result appears one edge later.
`timescale 1ns/1ps
module sine_approx
  import angle_lin_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Phase in, sine out
  input wire logic [ANGLE_W-1:0] phase,
  output logic signed [15:0] sine
);
  logic [14:0] halfFrac;
  logic [29:0] product;
  logic [16:0] magnitude;
  logic [15:0] magClamped;

  // Parabola 4u(1-u) per half turn: peak error near 5 %, traded for no table
  always_comb begin
    halfFrac = phase[14:0];
    product = {15'h0000, halfFrac} * {14'h0000, 16'h8000 - {1'b0, halfFrac}};
    magnitude = product[29:13];
    if (magnitude > {1'b0, SINE_MAX}) begin
      magClamped = SINE_MAX;
    end else begin
      magClamped = magnitude[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sine <= 16'sh0000;
    end else if (phase[15]) begin
      sine <= -$signed(magClamped);
    end else begin
      sine <= $signed(magClamped);
    end
  end
endmodule : sine_approx

// >>> rtl/angle_linearization_unit.sv
// Angle linearization stage: segmented or harmonic correction of a raw angle.
// Assumes a nonvolatile store that answers a read one clock after nvRead,
// and a host write port that is already decoded from the serial interface.
`timescale 1ns/1ps

module angle_linearization_unit
  import angle_lin_pkg::*;
#(
  parameter int NUM_HARM = HARM_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Raw angle in
  input wire logic angleValid,
  input wire logic [ANGLE_W-1:0] angleIn,
  output logic angleReady,
  // Corrected angle out
  output logic angleOutValid,
  output logic [ANGLE_W-1:0] angleOut,
  output logic [OUT_W-1:0] angleOut12,
  // Nonvolatile store read port
  output logic nvRead,
  output logic [5:0] nvAddr,
  input wire logic [15:0] nvData,
  // Host SRAM write port
  input wire logic coefWrite,
  input wire logic [5:0] coefAddr,
  input wire logic [15:0] coefData,
  // Status
  output logic initDone,
  output logic [1:0] activeMode
);
  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_SEG, ST_FACTOR, ST_OFFSET, ST_SINE, ST_TERM, ST_DONE
  } state_t;

  state_t state_reg;
  logic [15:0] coef_reg [COEF_WORDS];
  logic [5:0] loadAddr_reg;
  logic loadPending_reg;
  logic [ANGLE_W-1:0] angle_reg;
  logic [ANGLE_W-1:0] arg_reg;
  logic [3:0] harm_reg;
  logic signed [19:0] acc_reg;
  logic [ANGLE_W-1:0] result_reg;
  logic signed [15:0] sine;

  logic [15:0] optionWord;
  logic harmEnable;
  logic segEnable;
  logic [1:0] segSelect;
  logic [SEG_BITS-1:0] segIdx;
  logic [SEG_BITS-1:0] segNextIdx;
  logic [FRAC_W-1:0] segFrac;
  logic [15:0] segLow;
  logic [15:0] segHigh;
  logic signed [15:0] segDiff;
  logic signed [28:0] segProd;
  logic [15:0] segValue;
  logic signed [31:0] termProd;
  logic signed [19:0] term;

  // Wrapping product of harmonic index and angle, modulo one rotation
  function automatic logic [ANGLE_W-1:0] mulWrap(input logic [3:0] n,
                                                 input logic [ANGLE_W-1:0] a);
    logic [19:0] full;
    full = {16'h0000, n} * {4'h0, a};
    return full[ANGLE_W-1:0];
  endfunction : mulWrap

  // Option word steers the method choice
  always_comb begin
    optionWord = coef_reg[OPTION_ADDR];
    harmEnable = optionWord[OPT_HARM_BIT];
    segEnable = optionWord[OPT_SEG_BIT];
    segSelect = optionWord[OPT_SEL_LSB +: 2];
  end

  // Segment lookup and interpolation
  always_comb begin
    segIdx = angle_reg[ANGLE_W-1 -: SEG_BITS];
    segFrac = angle_reg[FRAC_W-1:0];
    segNextIdx = segIdx + 4'h1;
    segLow = coef_reg[SEG_BASE + {2'b00, segIdx}];
    segHigh = coef_reg[SEG_BASE + {2'b00, segNextIdx}];
    segDiff = $signed(segHigh - segLow);
    segProd = segDiff * $signed({1'b0, segFrac});
    segValue = segLow + 16'(segProd >>> FRAC_W);
  end

  // Harmonic term: amplitude times sine of the offset argument
  always_comb begin
    termProd = $signed(coef_reg[AMP_BASE + {2'b00, harm_reg} - 6'h01]) * sine;
    term = 20'(termProd >>> SINE_FRAC);
  end

  sine_approx u_sine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .phase(arg_reg),
    .sine(sine)
  );

  // Coefficient SRAM: filled from the store, then host writes apply live
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < COEF_WORDS; i++) begin
        coef_reg[i] <= (i == int'(OPTION_ADDR)) ? OPTION_RESET : COEF_RESET;
      end
    end else if (state_reg == ST_LOAD) begin
      if (loadPending_reg) begin
        coef_reg[loadAddr_reg] <= nvData;
      end
    end else if (coefWrite && coefAddr <= LAST_ADDR) begin
      coef_reg[coefAddr] <= coefData;
    end
  end

  // Start-up copy sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nvRead <= 1'b0;
      nvAddr <= 6'h00;
      loadAddr_reg <= 6'h00;
      loadPending_reg <= 1'b0;
      initDone <= 1'b0;
    end else if (state_reg == ST_LOAD) begin
      loadPending_reg <= nvRead;
      loadAddr_reg <= nvAddr;
      if (!nvRead && !loadPending_reg) begin
        nvRead <= 1'b1;
      end else if (nvRead && nvAddr == LAST_ADDR) begin
        nvRead <= 1'b0;
      end else if (nvRead) begin
        nvAddr <= nvAddr + 6'h01;
      end
      if (loadPending_reg && loadAddr_reg == LAST_ADDR) begin
        initDone <= 1'b1;
      end
    end
  end

  // Method sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_LOAD;
    end else begin
      unique case (state_reg)
        ST_LOAD: begin
          if (loadPending_reg && loadAddr_reg == LAST_ADDR) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (angleValid) begin
            if (harmEnable) begin
              state_reg <= ST_FACTOR;
            end else if (segEnable) begin
              state_reg <= ST_SEG;
            end else begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_SEG: state_reg <= ST_DONE;
        ST_FACTOR: state_reg <= ST_OFFSET;
        ST_OFFSET: state_reg <= ST_SINE;
        ST_SINE: state_reg <= ST_TERM;
        ST_TERM: begin
          if (harm_reg == 4'(NUM_HARM)) begin
            state_reg <= ST_DONE;
          end else begin
            state_reg <= ST_FACTOR;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Datapath: angle capture, harmonic loop, result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      angle_reg <= 16'h0000;
      arg_reg <= 16'h0000;
      harm_reg <= 4'h0;
      acc_reg <= 20'sh00000;
      result_reg <= 16'h0000;
      activeMode <= MODE_NONE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          angle_reg <= angleIn;
          harm_reg <= 4'h1;
          acc_reg <= 20'sh00000;
          result_reg <= angleIn;
          if (angleValid) begin
            activeMode <= harmEnable ? MODE_HARM : (segEnable ? MODE_SEG : MODE_NONE);
          end
        end
        ST_SEG: begin
          if (segSelect == SEL_OFFSET) begin
            result_reg <= angle_reg + segValue;
          end else begin
            result_reg <= segValue;
          end
        end
        ST_FACTOR: arg_reg <= mulWrap(harm_reg, angle_reg);
        ST_OFFSET: arg_reg <= arg_reg + coef_reg[PHASE_BASE + {2'b00, harm_reg} - 6'h01];
        ST_TERM: begin
          acc_reg <= acc_reg + term;
          harm_reg <= harm_reg + 4'h1;
          if (harm_reg == 4'(NUM_HARM)) begin
            result_reg <= angle_reg + 16'(acc_reg + term);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      angleOutValid <= 1'b0;
      angleOut <= 16'h0000;
      angleOut12 <= 12'h000;
      angleReady <= 1'b0;
    end else begin
      angleOutValid <= (state_reg == ST_DONE);
      angleReady <= (state_reg == ST_IDLE && !angleValid) || state_reg == ST_DONE;
      if (state_reg == ST_DONE) begin
        angleOut <= result_reg;
        angleOut12 <= result_reg[ANGLE_W-1 -: OUT_W];
      end
    end
  end
endmodule : angle_linearization_unit

// >>> testbench/angle_lin_chk.sv
// Checker for the angle linearization unit, bound to its top ports.
// Assumes one clock domain and resetn active low.
`timescale 1ns/1ps
module angle_lin_chk
  import angle_lin_pkg::*;
#(
  parameter int NUM_HARM = HARM_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Angle path
  input wire logic angleValid,
  input wire logic angleReady,
  input wire logic angleOutValid,
  input wire logic [ANGLE_W-1:0] angleOut,
  input wire logic [OUT_W-1:0] angleOut12,
  // Store and status
  input wire logic nvRead,
  input wire logic [5:0] nvAddr,
  input wire logic initDone,
  input wire logic [1:0] activeMode
);
  localparam int HWAIT = 1 + 4 * NUM_HARM;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence took;
    angleValid && angleReady;
  endsequence
  sequence tookHarm;
    took ##1 activeMode == MODE_HARM;
  endsequence
  sequence tookNone;
    took ##1 activeMode == MODE_NONE;
  endsequence
  sequence tookSeg;
    took ##1 activeMode == MODE_SEG;
  endsequence
  a_busy_refuses: assert property (took |=> !angleReady)
    else $error("ready while busy");
  a_short_latency: assert property (tookNone |-> !angleOutValid ##1 angleOutValid)
    else $error("uncorrected result late");
  a_seg_latency: assert property (tookSeg |-> !angleOutValid ##1 !angleOutValid ##1 angleOutValid)
    else $error("segmented result late");
  a_harm_latency: assert property (tookHarm |-> ##HWAIT angleOutValid)
    else $error("harmonic result late");
  a_out_trunc: assert property (angleOutValid |-> angleOut12 == angleOut[15:4])
    else $error("truncated output wrong");
  a_out_hold: assert property ($changed(angleOut) |-> angleOutValid)
    else $error("output moved without result");
  a_load_first: assert property ($rose(nvRead) |-> nvAddr == SEG_BASE)
    else $error("load starts elsewhere");
  a_load_step: assert property (nvRead && $past(nvRead) |-> nvAddr == $past(nvAddr) + 6'h01)
    else $error("load address skipped");
  a_ready_init: assert property (!initDone |-> !angleReady)
    else $error("ready before load");
endmodule : angle_lin_chk

bind angle_linearization_unit angle_lin_chk #(.NUM_HARM(NUM_HARM)) chk (
  .ref_clk(ref_clk), .resetn(resetn), .angleValid(angleValid), .angleReady(angleReady),
  .angleOutValid(angleOutValid), .angleOut(angleOut), .angleOut12(angleOut12),
  .nvRead(nvRead), .nvAddr(nvAddr), .initDone(initDone), .activeMode(activeMode));

// >>> testbench/nv_store_model.sv
// Nonvolatile coefficient store read by the unit during start-up.
// Assumes a synchronous read: data follows one edge after the address.
`timescale 1ns/1ps
module nv_store_model
  import angle_lin_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Read port
  input wire logic nvRead,
  input wire logic [5:0] nvAddr,
  output logic [15:0] nvData
);
  logic [15:0] mem [COEF_WORDS];
  initial begin
    nvData = 16'h0000;
    foreach (mem[i]) mem[i] = COEF_RESET;
    // Half slope endpoints so correction is visible
    for (int k = 0; k < SEG_COUNT; k++) mem[k] = 16'(k * 16'h0800);
    mem[OPTION_ADDR] = 16'h0002;
  end
  // Idle bus inverts every bit each edge, so the last word returns every second cycle
  always @(posedge ref_clk) begin
    if (nvRead) nvData <= mem[nvAddr];
    else nvData <= ~nvData;
  end
endmodule : nv_store_model

// >>> testbench/testbench.sv
// Self-checking bench for the angle linearization unit.
// Assumes the store model holds endpoints k*0x800 and segmented mode.
`timescale 1ns/1ps
module testbench
  import angle_lin_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic angleValid = 1'b0;
  logic [15:0] angleIn = 16'h0000;
  logic coefWrite = 1'b0;
  logic [5:0] coefAddr = 6'h00;
  logic [15:0] coefData = 16'h0000;
  logic angleReady, angleOutValid, nvRead, initDone;
  logic [15:0] angleOut, nvData;
  logic [11:0] angleOut12;
  logic [5:0] nvAddr;
  logic [1:0] activeMode;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  localparam logic [15:0] SEG_IN [4] = '{16'h0000, 16'h1800, 16'hF800, 16'hFFFF};
  always #10 ref_clk = ~ref_clk;
  angle_linearization_unit DUT (.ref_clk(ref_clk), .resetn(resetn), .angleValid(angleValid),
    .angleIn(angleIn), .angleReady(angleReady), .angleOutValid(angleOutValid),
    .angleOut(angleOut), .angleOut12(angleOut12), .nvRead(nvRead), .nvAddr(nvAddr),
    .nvData(nvData), .coefWrite(coefWrite), .coefAddr(coefAddr), .coefData(coefData),
    .initDone(initDone), .activeMode(activeMode));
  nv_store_model store (.ref_clk(ref_clk), .nvRead(nvRead), .nvAddr(nvAddr), .nvData(nvData));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic put(input logic [5:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    coefWrite = 1'b1;
    coefAddr = a;
    coefData = d;
    @(negedge ref_clk);
    coefWrite = 1'b0;
  endtask : put
  task automatic run(input logic [15:0] a, input logic [15:0] e, input logic [1:0] m,
                     input int lat);
    int n;
    // Counted in edges from the take edge
    n = 1;
    @(negedge ref_clk);
    while (angleReady !== 1'b1) @(negedge ref_clk);
    angleValid = 1'b1;
    angleIn = a;
    @(negedge ref_clk);
    angleValid = 1'b0;
    while (angleOutValid !== 1'b1 && n < 100) begin
      n++;
      @(negedge ref_clk);
    end
    chk("angleOut", e, angleOut);
    chk("angleOut12", {4'h0, e[15:4]}, {4'h0, angleOut12});
    chk("activeMode", {14'h0000, m}, {14'h0000, activeMode});
    chk("latency", 16'(lat), 16'(n));
  endtask : run
  // Expected segmented result with the model's endpoints
  function automatic logic [15:0] seg(input logic [15:0] a);
    logic [15:0] lo, hi;
    logic signed [31:0] d;
    lo = {1'b0, a[15:12], 11'h000};
    hi = (a[15:12] == 4'hF) ? 16'h0000 : lo + 16'h0800;
    d = signed'(16'(hi - lo));
    d = (d * signed'({20'h00000, a[11:0]})) >>> 12;
    return lo + 16'(d);
  endfunction : seg
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Ceiling well above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    // Calibration sweep: zero and every sixteenth of a turn lands on an endpoint
    for (int k = 0; k < SEG_COUNT; k++) run(16'(k * 16'h1000), 16'(k * 16'h0800), MODE_SEG, 3);
    foreach (SEG_IN[i]) run(SEG_IN[i], seg(SEG_IN[i]), MODE_SEG, 3);
    chk("initDone", 16'h0001, {15'h0000, initDone});
    $display("test segmented done");
    put(OPTION_ADDR, 16'h0006);
    run(16'h1800, 16'h2400, MODE_SEG, 3);
    put(SEG_BASE + 6'h01, 16'h1000);
    run(16'h1000, 16'h2000, MODE_SEG, 3);
    put(OPTION_ADDR, 16'h0000);
    run(16'h1234, 16'h1234, MODE_NONE, 2);
    $display("test modes done");
    put(OPTION_ADDR, 16'h0003);
    run(16'h1234, 16'h1234, MODE_HARM, 62);
    put(AMP_BASE, 16'h4000);
    put(PHASE_BASE, 16'h4000);
    put(AMP_BASE + 6'h0E, 16'h2000);
    put(PHASE_BASE + 6'h0E, 16'hC000);
    run(16'h0000, 16'h1FFF, MODE_HARM, 62);
    run(16'hFFFF, 16'h1FFE, MODE_HARM, 62);
    $display("test harmonic done");
    conclude();
  end
endmodule : testbench
